// ---- hdl/jaf_top.v ----
`timescale 1ns/1ps
`include "jaf_defines.vh"
module jaf_top #(
   parameter LOOP_SHIFT = `JAF_LOOP_SHIFT
) (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // AXI4-Lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   // Jittery line side, one bit per channel
   input  wire [3:0]  transmit_line_clock_in,
   input  wire [3:0]  jittery_pos_rail_in,
   input  wire [3:0]  jittery_neg_rail_in,
   // Smoothed terminal side, one bit per channel
   output wire [3:0]  smoothed_clock_out,
   output wire [3:0]  smoothed_pos_rail_out,
   output wire [3:0]  smoothed_neg_rail_out,
   output wire [3:0]  fifo_near_full_flag,
   // Interrupt
   output wire        irq
);
   localparam NCH   = 4;
   localparam NEV   = NCH * `JAF_EV_STRIDE;
   localparam PTR_W = 5;
   localparam CNT_W = 6;
   localparam FMAX  = 32;

   // Byte-lane merge used by every writable register
   function [31:0] jaf_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  strb;
      integer      b;
      begin
         jaf_merge = old_v;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               jaf_merge[8*b +: 8] = new_v[8*b +: 8];
            end
         end
      end
   endfunction

   // Pointer advance with wrap at the selected depth
   function [PTR_W-1:0] jaf_next_ptr;
      input [PTR_W-1:0] p;
      input             d32;
      begin
         jaf_next_ptr = (p + 5'h01) & (d32 ? `JAF_MASK_LARGE : `JAF_MASK_SMALL);
      end
   endfunction

   // Register file state
   reg [31:0]     ctrl_r;
   reg [31:0]     inc_leg_r;
   reg [31:0]     inc_son_r;
   reg [NEV-1:0]  irq_stat_r;
   reg [NEV-1:0]  irq_en_r;
   reg            irq_r;
   wire [NEV-1:0] evt;
   wire [NCH-1:0] near_w;
   wire [31:0]    fill_bus;

   // AXI write side
   reg            awready_r;
   reg            wready_r;
   reg            bvalid_r;
   reg [1:0]      bresp_r;
   reg            aw_hold_r;
   reg            w_hold_r;
   reg [7:0]      waddr_r;
   reg [31:0]     wdata_r;
   reg [3:0]      wstrb_r;
   // AXI read side
   reg            arready_r;
   reg            rvalid_r;
   reg [1:0]      rresp_r;
   reg [31:0]     rdata_r;

   wire           do_write = aw_hold_r & w_hold_r & ~bvalid_r;
   wire           clr_hit  = do_write & (waddr_r == `JAF_ADDR_IRQ_CLR);
   wire [31:0]    clr_word = jaf_merge(32'h0000_0000, wdata_r, wstrb_r);
   wire [31:0]    en_word  = jaf_merge({{(32-NEV){1'b0}}, irq_en_r},
                                       wdata_r, wstrb_r);
   wire [NEV-1:0] clr_mask = clr_hit ? clr_word[NEV-1:0] : {NEV{1'b0}};
   wire [NEV-1:0] irq_stat_nxt = (irq_stat_r & ~clr_mask) | evt;

   // Write channel: address and data taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         waddr_r   <= 8'h00;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `JAF_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_hold_r <= 1'b1;
            waddr_r   <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            case (waddr_r)
               `JAF_ADDR_CTRL, `JAF_ADDR_INC_LEG, `JAF_ADDR_INC_SON,
               `JAF_ADDR_IRQ_EN, `JAF_ADDR_IRQ_CLR:
                  bresp_r <= `JAF_RESP_OKAY;
               default:
                  bresp_r <= `JAF_RESP_SLVERR;
            endcase
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   // Writable registers and sticky events
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r     <= `JAF_CTRL_RST;
         inc_leg_r  <= `JAF_INC_RST;
         inc_son_r  <= `JAF_INC_RST;
         irq_en_r   <= {NEV{1'b0}};
         irq_stat_r <= {NEV{1'b0}};
         irq_r      <= 1'b0;
      end else begin
         if (do_write) begin
            case (waddr_r)
               `JAF_ADDR_CTRL:
                  ctrl_r <= jaf_merge(ctrl_r, wdata_r, wstrb_r);
               `JAF_ADDR_INC_LEG:
                  inc_leg_r <= jaf_merge(inc_leg_r, wdata_r, wstrb_r);
               `JAF_ADDR_INC_SON:
                  inc_son_r <= jaf_merge(inc_son_r, wdata_r, wstrb_r);
               `JAF_ADDR_IRQ_EN:
                  irq_en_r <= en_word[NEV-1:0];
               default: ;
            endcase
         end
         // New event wins over a clear in the same cycle
         irq_stat_r <= irq_stat_nxt;
         irq_r      <= |(irq_stat_r & irq_en_r);
      end
   end

   // Read channel, one read at a time
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rresp_r   <= `JAF_RESP_OKAY;
         rdata_r   <= 32'h0000_0000;
      end else begin
         if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rresp_r   <= `JAF_RESP_OKAY;
            case (s_axi_araddr)
               `JAF_ADDR_CTRL:     rdata_r <= ctrl_r;
               `JAF_ADDR_INC_LEG:  rdata_r <= inc_leg_r;
               `JAF_ADDR_INC_SON:  rdata_r <= inc_son_r;
               `JAF_ADDR_FLAGS:    rdata_r <= {{(32-NCH){1'b0}}, near_w};
               `JAF_ADDR_FILL:     rdata_r <= fill_bus;
               `JAF_ADDR_IRQ_STAT: rdata_r <= {{(32-NEV){1'b0}}, irq_stat_r};
               `JAF_ADDR_IRQ_EN:   rdata_r <= {{(32-NEV){1'b0}}, irq_en_r};
               `JAF_ADDR_IRQ_CLR:  rdata_r <= 32'h0000_0000;
               default: begin
                  rdata_r <= 32'h0000_0000;
                  rresp_r <= `JAF_RESP_SLVERR;
               end
            endcase
         end
         if (rvalid_r && s_axi_rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   // Line inputs come from another clock domain
   wire [NCH-1:0] lclk_s;
   wire [NCH-1:0] lpos_s;
   wire [NCH-1:0] lneg_s;

   jaf_sync #(
      .W (3 * NCH)
   ) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in ({transmit_line_clock_in, jittery_pos_rail_in,
                  jittery_neg_rail_in}),
      .sync_out ({lclk_s, lpos_s, lneg_s})
   );

   genvar i;
   generate
      for (i = 0; i < NCH; i = i + 1) begin : g_ch
         reg [1:0]       mem [0:FMAX-1];
         reg [PTR_W-1:0] wp_r;
         reg [PTR_W-1:0] rp_r;
         reg [CNT_W-1:0] cnt_r;
         reg [31:0]      acc_r;
         reg             lclk_d_r;
         reg             sclk_r;
         reg             pos_r;
         reg             neg_r;
         reg             near_r;
         reg             ev_near_r;
         reg             ev_ovf_r;
         reg             ev_unf_r;

         wire d32  = ctrl_r[`JAF_CF_STRIDE*i + `JAF_CF_DEPTH32];
         wire dis  = ctrl_r[`JAF_CF_STRIDE*i + `JAF_CF_DISABLE];
         wire son  = ctrl_r[`JAF_CF_STRIDE*i + `JAF_CF_SONET];
         wire [CNT_W-1:0] depth = d32 ? `JAF_DEPTH_LARGE : `JAF_DEPTH_SMALL;
         wire [CNT_W-1:0] half  = d32 ? `JAF_HALF_LARGE : `JAF_HALF_SMALL;
         wire [CNT_W-1:0] limit = depth - `JAF_LIMIT_MARGIN;

         // Line clock rising edge writes, acc MSB rising edge reads
         wire wr_tick = lclk_s[i] & ~lclk_d_r;
         wire full    = (cnt_r == depth);
         wire empty   = (cnt_r == {CNT_W{1'b0}});
         wire do_wr   = wr_tick & ~full & ~dis;
         wire [31:0] acc_nxt;
         wire rd_tick = acc_nxt[31] & ~acc_r[31] & ~dis;
         wire do_rd   = rd_tick & ~empty;
         wire [CNT_W-1:0] cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, do_wr}
                                    - {{(CNT_W-1){1'b0}}, do_rd};

         // Proportional loop on fill error; small gain keeps bandwidth low
         wire signed [CNT_W:0] err = $signed({1'b0, cnt_r})
                                     - $signed({1'b0, half});
         wire [31:0] corr = {{(32-CNT_W-1){err[CNT_W]}}, err}
                            << LOOP_SHIFT;
         wire [31:0] base = son ? inc_son_r : inc_leg_r;
         assign acc_nxt = acc_r + base + corr;

         always @(posedge aclk) begin
            if (do_wr) begin
               mem[wp_r] <= {lpos_s[i], lneg_s[i]};
            end
         end

         always @(posedge aclk) begin
            if (!aresetn) begin
               wp_r      <= {PTR_W{1'b0}};
               rp_r      <= {PTR_W{1'b0}};
               cnt_r     <= {CNT_W{1'b0}};
               acc_r     <= 32'h0000_0000;
               lclk_d_r  <= 1'b0;
               sclk_r    <= 1'b0;
               pos_r     <= 1'b0;
               neg_r     <= 1'b0;
               near_r    <= 1'b0;
               ev_near_r <= 1'b0;
               ev_ovf_r  <= 1'b0;
               ev_unf_r  <= 1'b0;
            end else begin
               lclk_d_r  <= lclk_s[i];
               ev_ovf_r  <= wr_tick & full & ~dis;
               ev_unf_r  <= rd_tick & empty;
               ev_near_r <= ~near_r & ~dis & (cnt_nxt >= limit);
               if (dis) begin
                  // Bypass: FIFO flushed, line clock and data pass through
                  wp_r   <= {PTR_W{1'b0}};
                  rp_r   <= {PTR_W{1'b0}};
                  cnt_r  <= {CNT_W{1'b0}};
                  acc_r  <= 32'h0000_0000;
                  near_r <= 1'b0;
                  sclk_r <= lclk_s[i];
                  if (wr_tick) begin
                     pos_r <= lpos_s[i];
                     neg_r <= lneg_s[i];
                  end
               end else begin
                  acc_r  <= acc_nxt;
                  sclk_r <= acc_nxt[31];
                  cnt_r  <= cnt_nxt;
                  // Set at depth-2, clear below it
                  near_r <= (cnt_nxt >= limit);
                  if (do_wr) begin
                     wp_r <= jaf_next_ptr(wp_r, d32);
                  end
                  if (do_rd) begin
                     rp_r  <= jaf_next_ptr(rp_r, d32);
                     pos_r <= mem[rp_r][1];
                     neg_r <= mem[rp_r][0];
                  end else if (rd_tick) begin
                     pos_r <= 1'b0;
                     neg_r <= 1'b0;
                  end
               end
            end
         end

         assign smoothed_clock_out[i]    = sclk_r;
         assign smoothed_pos_rail_out[i] = pos_r;
         assign smoothed_neg_rail_out[i] = neg_r;
         assign fifo_near_full_flag[i]   = near_r;
         assign near_w[i]                = near_r;
         assign evt[`JAF_EV_STRIDE*i + `JAF_EV_NEAR] = ev_near_r;
         assign evt[`JAF_EV_STRIDE*i + `JAF_EV_OVF]  = ev_ovf_r;
         assign evt[`JAF_EV_STRIDE*i + `JAF_EV_UNF]  = ev_unf_r;
         assign fill_bus[`JAF_FILL_STRIDE*i +: `JAF_FILL_STRIDE] =
            {{(`JAF_FILL_STRIDE-CNT_W){1'b0}}, cnt_r};
      end
   endgenerate

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;
   assign irq           = irq_r;
endmodule // jaf_top

// ---- hdl/jaf_defines.vh ----
// Behaviour
// - Four independent channels, each with its own line clock, two rail inputs, smoothed outputs and limit flag.
// - Each channel writes its rail bits into its FIFO on the rising edges of the line clock that comes with them.
// - The FIFO depth of each channel is selectable as 16 or 32 bits.
// - FIFO reads are timed by the smoothed clock, not by the incoming line clock.
// - The limit flag is set while the FIFO holds at least depth minus 2 bits.
// - The smoothed clock that reads the FIFO is also driven out on the smoothed clock pin.
// - Data read from the FIFO is driven out on the positive and negative smoothed rail pins.
// - A digital loop steered by the FIFO fill makes the smoothed clock from the reference alone.
// - The loop bandwidth is kept well below 100 Hz.
// - A per-channel disable bit turns the attenuation off for that channel.
// - A per-channel select bit picks the SONET rate instead of the DS3 or E3 rate.
`ifndef JAF_DEFINES_VH
`define JAF_DEFINES_VH

// Register byte addresses
`define JAF_ADDR_CTRL      8'h00
`define JAF_ADDR_INC_LEG   8'h04
`define JAF_ADDR_INC_SON   8'h08
`define JAF_ADDR_FLAGS     8'h0c
`define JAF_ADDR_FILL      8'h10
`define JAF_ADDR_IRQ_STAT  8'h14
`define JAF_ADDR_IRQ_EN    8'h18
`define JAF_ADDR_IRQ_CLR   8'h1c

// Control fields, one nibble per channel
`define JAF_CF_STRIDE      4
`define JAF_CF_DEPTH32     0
`define JAF_CF_DISABLE     1
`define JAF_CF_SONET       2
`define JAF_CTRL_RST       32'h0000_0000

// Event bits, three per channel
`define JAF_EV_STRIDE      3
`define JAF_EV_NEAR        0
`define JAF_EV_OVF         1
`define JAF_EV_UNF         2

// Fill field stride in the fill register
`define JAF_FILL_STRIDE    8

// FIFO geometry
`define JAF_DEPTH_SMALL    6'd16
`define JAF_DEPTH_LARGE    6'd32
`define JAF_HALF_SMALL     6'd8
`define JAF_HALF_LARGE     6'd16
`define JAF_LIMIT_MARGIN   6'd2
`define JAF_MASK_SMALL     5'h0f
`define JAF_MASK_LARGE     5'h1f

// Timing: bench line clock and system clock in ns
`define JAF_LINK_PERIOD_NS 160
`define JAF_CLK_PERIOD_NS  20
`define JAF_INC_RST ((32'h8000_0000 / (`JAF_LINK_PERIOD_NS / `JAF_CLK_PERIOD_NS)) * 2)
`define JAF_LOOP_SHIFT     5

// AXI responses
`define JAF_RESP_OKAY      2'b00
`define JAF_RESP_SLVERR    2'b10

`endif

// ---- hdl/jaf_sync.v ----
`timescale 1ns/1ps
module jaf_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         aclk,
   input  wire         aresetn,
   // Asynchronous input and clean level
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;
   reg [W-1:0] out_r;
   integer     k;

   // A change counts only once stages two and three agree
   always @(posedge aclk) begin
      if (!aresetn) begin
         s1_r  <= {W{1'b0}};
         s2_r  <= {W{1'b0}};
         s3_r  <= {W{1'b0}};
         out_r <= {W{1'b0}};
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (k = 0; k < W; k = k + 1) begin
            if (s2_r[k] == s3_r[k]) begin
               out_r[k] <= s3_r[k];
            end
         end
      end
   end

   assign sync_out = out_r;
endmodule // jaf_sync

// ---- tb/jaf_top_assertions.sv ----
`timescale 1ns/1ps
`include "jaf_defines.vh"
module jaf_chk (
   // Clock and reset
   input logic        aclk,
   input logic        aresetn,
   // Bus handshakes
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic [1:0]  s_axi_bresp,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0]  s_axi_rresp,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   // Smoothed side
   input logic [3:0]  smoothed_clock_out,
   input logic [3:0]  smoothed_pos_rail_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_aw_once;
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
   endproperty
   a_aw_once: assert property (p_aw_once) else $error("aw taken twice");

   property p_b_soon;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_b_soon: assert property (p_b_soon) else $error("no write response");

   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");

   property p_b_drop;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready
         && s_axi_wready;
   endproperty
   a_b_drop: assert property (p_b_drop) else $error("write not closed");

   property p_r_next;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_r_next: assert property (p_r_next) else $error("read not answered");

   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
         && $stable(s_axi_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data moved");

   property p_r_drop;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##0 s_axi_arready;
   endproperty
   a_r_drop: assert property (p_r_drop) else $error("read not closed");

   property p_r_err;
      s_axi_rvalid && s_axi_rresp == `JAF_RESP_SLVERR |-> s_axi_rdata == 0;
   endproperty
   a_r_err: assert property (p_r_err) else $error("refused read data");

   // Channel 0 stays enabled all run, so rails only move with its clock
   property p_rail_clk;
      $changed(smoothed_pos_rail_out[0]) |-> $rose(smoothed_clock_out[0]);
   endproperty
   a_rail_clk: assert property (p_rail_clk) else $error("rail off clock");
endmodule // jaf_chk

bind jaf_top jaf_chk u_chk (
   .aclk                  (aclk),
   .aresetn               (aresetn),
   .s_axi_awvalid         (s_axi_awvalid),
   .s_axi_awready         (s_axi_awready),
   .s_axi_wvalid          (s_axi_wvalid),
   .s_axi_wready          (s_axi_wready),
   .s_axi_bresp           (s_axi_bresp),
   .s_axi_bvalid          (s_axi_bvalid),
   .s_axi_bready          (s_axi_bready),
   .s_axi_arvalid         (s_axi_arvalid),
   .s_axi_arready         (s_axi_arready),
   .s_axi_rdata           (s_axi_rdata),
   .s_axi_rresp           (s_axi_rresp),
   .s_axi_rvalid          (s_axi_rvalid),
   .s_axi_rready          (s_axi_rready),
   .smoothed_clock_out    (smoothed_clock_out),
   .smoothed_pos_rail_out (smoothed_pos_rail_out)
);

// ---- tb/jaf_line_model.sv ----
`timescale 1ns/1ps
module jaf_line_model #(
   parameter logic [15:0] PAT = 16'hb4e1
) (
   // Frame control
   input  logic       run,
   // Line side, all channels alike
   output logic [3:0] line_clk,
   output logic [3:0] pos,
   output logic [3:0] neg,
   output int         n_sent
);
   // Odd start offset keeps the line clock unrelated to aclk
   initial begin
      line_clk = 4'h0;
      pos = 4'hf;
      neg = 4'hf;
      n_sent = 0;
      #7;
      forever begin
         if (run) begin
            pos = {4{PAT[n_sent % 16]}};
            neg = ~pos;
            #80 line_clk = 4'hf;
            n_sent = n_sent + 1;
            #80 line_clk = 4'h0;
         end else begin
            // Released rails float to the pull-up level
            pos = 4'hf;
            neg = 4'hf;
            #20;
         end
      end
   end
endmodule // jaf_line_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`include "jaf_defines.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   localparam logic [15:0] PAT = 16'hb4e1;
   logic        aclk    = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr  = 8'h00;
   logic        awvalid = 1'b0;
   logic [31:0] wdata   = 32'h0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic [7:0]  araddr  = 8'h00;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic        run     = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [3:0]  lclk, lpos, lneg, sclk, spos, sneg, near;
   logic [3:0]  sclk_q = 4'h0;
   logic [1:0]  outq[4][$];
   int          sent;
   int          n_mismatch = 0;
   int          checks_done = 0;
   logic [7:0]  ra[6] = '{`JAF_ADDR_CTRL, `JAF_ADDR_INC_LEG, `JAF_ADDR_INC_SON,
                          `JAF_ADDR_IRQ_EN, `JAF_ADDR_IRQ_CLR, 8'h20};
   logic [33:0] rv[6] = '{34'h0, 34'h0_2000_0000, 34'h0_2000_0000, 34'h0,
                          34'h0, 34'h2_0000_0000};

   always #(`JAF_CLK_PERIOD_NS / 2) aclk = ~aclk;

   jaf_top uut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .transmit_line_clock_in(lclk),
      .jittery_pos_rail_in(lpos), .jittery_neg_rail_in(lneg),
      .smoothed_clock_out(sclk), .smoothed_pos_rail_out(spos),
      .smoothed_neg_rail_out(sneg), .fifo_near_full_flag(near), .irq(irq)
   );

   jaf_line_model #(.PAT(PAT)) u_line (
      .run(run), .line_clk(lclk), .pos(lpos), .neg(lneg), .n_sent(sent)
   );

   // Sample rails at the smoothed clock fall, mid-bit in both modes
   always @(posedge aclk) begin
      sclk_q <= sclk;
      for (int c = 0; c < 4; c++)
         if (!sclk[c] && sclk_q[c])
            outq[c].push_back({spos[c], sneg[c]});
   end

   task automatic finish_test(input bit to);
      if (to)
         n_mismatch++;
      if (n_mismatch == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
      int k;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (!bvalid && k < 50);
      if (!bvalid)
         finish_test(1'b1);
      `CHK(bresp, er)
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      int k;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
         if (arready)
            arvalid <= 1'b0;
      end while (!rvalid && k < 50);
      if (!rvalid)
         finish_test(1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic run_bits(input int n);
      int k;
      int stop;
      stop = sent + n;
      run <= 1'b1;
      for (k = 0; k < 4000 && sent < stop; k++)
         @(posedge aclk);
      if (k == 4000)
         finish_test(1'b1);
      run <= 1'b0;
   endtask

   task automatic drain();
      int k;
      logic [31:0] d;
      logic [1:0] r;
      for (k = 0; k < 200; k++) begin
         axr(`JAF_ADDR_FILL, d, r);
         if (d == 32'h0)
            break;
      end
      if (k == 200)
         finish_test(1'b1);
      repeat (8) @(posedge aclk);
   endtask

   // Underflow gaps read as 0/0 and are skipped; order must hold
   task automatic chk_seq();
      int j;
      for (int c = 0; c < 4; c++) begin
         j = 0;
         for (int i = 0; i < outq[c].size(); i++)
            if (outq[c][i] !== 2'b00) begin
               `CHK(outq[c][i], {PAT[j % 16], ~PAT[j % 16]})
               j++;
            end
         `CHK(j >= 20, 1'b1)
         outq[c].delete();
      end
   endtask

   initial begin
      logic [31:0] d;
      logic [31:0] e;
      logic [1:0]  r;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 6; i++) begin
         axr(ra[i], d, r);
         `CHK({r, d}, rv[i])
      end
      axw(`JAF_ADDR_FLAGS, 32'hf, `JAF_RESP_SLVERR);
      axr(`JAF_ADDR_IRQ_STAT, d, r);
      `CHK({d[8], irq}, 2'b10)
      axw(`JAF_ADDR_IRQ_EN, 32'h100, `JAF_RESP_OKAY);
      repeat (3) @(posedge aclk);
      `CHK(irq, 1'b1)
      axw(`JAF_ADDR_CTRL, 32'h200, `JAF_RESP_OKAY);
      axw(`JAF_ADDR_IRQ_CLR, 32'h100, `JAF_RESP_OKAY);
      repeat (3) @(posedge aclk);
      `CHK(irq, 1'b0)
      axw(`JAF_ADDR_CTRL, 32'h4120, `JAF_RESP_OKAY);
      run_bits(48);
      drain();
      chk_seq();
      axw(`JAF_ADDR_INC_SON, 32'h1, `JAF_RESP_OKAY);
      run_bits(48);
      axr(`JAF_ADDR_FILL, d, r);
      axr(`JAF_ADDR_FLAGS, e, r);
      for (int i = 0; i < 4; i++)
         `CHK(e[i], d[8*i +: 6] >= (i == 2 ? 30 : 14))
      `CHK(d[29:24] > d[5:0], 1'b1)
      `CHK(e[3:0], 4'h8)
      `CHK(near, 4'h8)
      axw(`JAF_ADDR_INC_SON, 32'h2000_0000, `JAF_RESP_OKAY);
      drain();
      axr(`JAF_ADDR_FLAGS, e, r);
      `CHK(e[3:0], 4'h0)
      `CHK(near, 4'h0)
      finish_test(1'b0);
   end
endmodule // tb
